/* core/paired_timer_mode_control.sv */
module paired_timer_mode_control
    import timer_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] sfrAddr,
    input  wire logic              sfrWrEn,
    input  wire logic              sfrRdEn,
    input  wire logic [REG_W-1:0]  sfrWrData,
    output logic [REG_W-1:0]       sfrRdData,
    input  wire logic              lowSpeedClock,
    input  wire logic              highSpeedTimebaseClock,
    input  wire logic              firstTimerExtClockPin,
    input  wire logic              secondTimerExtClockPin,
    input  wire logic              thirdTimerExtClockPin,
    input  wire logic              fourthTimerExtClockPin,
    input  wire logic              fifthTimerExtClockPin,
    output logic                   firstTimerIrq,
    output logic                   secondTimerIrq,
    output logic                   thirdTimerIrq,
    output logic                   fourthTimerIrq,
    output logic                   fifthTimerIrq,
    output logic                   sixthTimerIrq,
    output logic                   fourthTimerOutput
);
    typedef struct packed {
        logic [NUM_TIMERS-1:0][REG_W-1:0] con0;
        logic [REG_W-1:0]                 rdData;
        logic                             outPin;
    } top_state_t;

    top_state_t                       s_reg;
    top_state_t                       s_next;
    logic [NUM_TIMERS-1:0]            extPins;
    logic [NUM_TIMERS-1:0]            ticks;
    logic [NUM_TIMERS-1:0]            runVec;
    logic [NUM_TIMERS-1:0]            statVec;
    logic [NUM_TIMERS-1:0]            irqVec;
    logic [NUM_TIMERS-1:0]            runWr;
    logic [NUM_TIMERS-1:0]            cntWr;
    logic [NUM_TIMERS-1:0]            cntRd;
    logic [NUM_TIMERS-1:0][CNT_W-1:0] cntVal;
    logic [NUM_PAIRS-1:0]             casc;
    logic [NUM_PAIRS-1:0]             togVec;

    // timer b shares the fourth pin, as the pin map does
    assign extPins = {fourthTimerExtClockPin, fifthTimerExtClockPin, fourthTimerExtClockPin,
                      thirdTimerExtClockPin, secondTimerExtClockPin, firstTimerExtClockPin};

    assign casc[0] = s_reg.con0[0][CASC_BIT_P0];
    assign casc[1] = s_reg.con0[2][CASC_BIT_HI];
    assign casc[2] = s_reg.con0[4][CASC_BIT_HI];

    function automatic logic isUpperCascaded(input int idx, input logic [NUM_PAIRS-1:0] c);
        isUpperCascaded = (idx % 2 == 1) && c[idx / 2];
    endfunction : isUpperCascaded

    always_comb begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            statVec[i] = runVec[i] && !isUpperCascaded(i, casc);
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g++) begin : gen_clk
            count_clock_select u_sel (
                .ref_clk (ref_clk),
                .rst_b   (rst_b),
                .sel     (s_reg.con0[g][CS_LSB +: 2]),
                .lowClk  (lowSpeedClock),
                .high_speed_timebase_clock  (highSpeedTimebaseClock),
                .extClk  (extPins[g]),
                .tick    (ticks[g])
            );
        end
        for (g = 0; g < NUM_PAIRS; g++) begin : gen_pair
            timer_pair #(
                .W (CNT_W)
            ) u_pair (
                .ref_clk   (ref_clk),
                .rst_b     (rst_b),
                .cascade   (casc[g]),
                .tickLo    (ticks[2*g]),
                .tickHi    (ticks[2*g+1]),
                .oneShotLo (s_reg.con0[2*g][OST_BIT]),
                .oneShotHi (s_reg.con0[2*g+1][OST_BIT]),
                .runData   (sfrWrData[RUN_BIT]),
                .runWrLo   (runWr[2*g]),
                .runWrHi   (runWr[2*g+1]),
                .cntWrLo   (cntWr[2*g]),
                .cntWrHi   (cntWr[2*g+1]),
                .rdLo      (cntRd[2*g]),
                .cntLo     (cntVal[2*g]),
                .cntHiRd   (cntVal[2*g+1]),
                .runLo     (runVec[2*g]),
                .runHi     (runVec[2*g+1]),
                .irqLo     (irqVec[2*g]),
                .irqHi     (irqVec[2*g+1]),
                .toggleHi  (togVec[g])
            );
        end
    endgenerate

    always_comb begin
        s_next        = s_reg;
        s_next.rdData = REG_ZERO;
        runWr         = '0;
        cntWr         = '0;
        cntRd         = '0;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            if (sfrAddr == CON0_ADDR[i]) begin
                // changes while counting act at once; software keeps it stopped
                if (sfrWrEn) begin
                    s_next.con0[i] = sfrWrData & CON0_WMASK[i];
                end
                if (sfrRdEn) begin
                    s_next.rdData = s_reg.con0[i];
                end
            end else if (sfrAddr == CON1_ADDR[i]) begin
                runWr[i] = sfrWrEn;
                if (sfrRdEn) begin
                    s_next.rdData[STAT_BIT] = statVec[i];
                    s_next.rdData[RUN_BIT]  = runVec[i];
                end
            end else if (sfrAddr == CNT_ADDR[i]) begin
                cntWr[i] = sfrWrEn;
                cntRd[i] = sfrRdEn;
                if (sfrRdEn) begin
                    s_next.rdData = cntVal[i];
                end
            end
        end
        // inactive level follows the polarity bit
        s_next.outPin = togVec[1] ^ s_reg.con0[3][NEG_BIT];
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg.con0   <= {NUM_TIMERS{CON0_RESET}};
            s_reg.rdData <= REG_ZERO;
            s_reg.outPin <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sfrRdData         = s_reg.rdData;
    assign fourthTimerOutput = s_reg.outPin;
    assign firstTimerIrq     = irqVec[0];
    assign secondTimerIrq    = irqVec[1];
    assign thirdTimerIrq     = irqVec[2];
    assign fourthTimerIrq    = irqVec[3];
    assign fifthTimerIrq     = irqVec[4];
    assign sixthTimerIrq     = irqVec[5];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    polarity_out_a: assert property (1'b1 |=> fourthTimerOutput == ($past(togVec[1]) ^ $past(s_reg.con0[3][NEG_BIT])))
        else $error("output polarity wrong");
    casc_write_a: assert property (sfrWrEn && sfrAddr == CON0_ADDR[0] |=> casc[0] == $past(sfrWrData[CASC_BIT_P0]))
        else $error("cascade bit not stored");
    mid_casc_a: assert property (sfrWrEn && sfrAddr == CON0_ADDR[2] |=> casc[1] == $past(sfrWrData[CASC_BIT_HI]))
        else $error("mid cascade bit not stored");
    high_casc_a: assert property (sfrWrEn && sfrAddr == CON0_ADDR[4] |=> casc[2] == $past(sfrWrData[CASC_BIT_HI]))
        else $error("high cascade bit not stored");
    mid_irq_off_a: assert property (casc[1] && $past(casc[1]) |-> !thirdTimerIrq)
        else $error("third irq while cascaded");
    // upper half of a joined pair never reports counting
    upper_stat_a: assert property (sfrRdEn && sfrAddr == CON1_ADDR[1] && casc[0] |=> !sfrRdData[STAT_BIT])
        else $error("cascaded timer 1 reports counting");
    mid_stat_a: assert property (sfrRdEn && sfrAddr == CON1_ADDR[3] && casc[1] |=> !sfrRdData[STAT_BIT])
        else $error("cascaded timer 9 reports counting");

    casc_irq_c: cover property (casc[0] && secondTimerIrq);
    off_code_c: cover property (s_reg.con0[2][CS_LSB +: 2] == CS_OFF && runVec[2]);
    one_shot_c: cover property (s_reg.con0[2][OST_BIT] && $fell(runVec[2]));
endmodule : paired_timer_mode_control

/* inc/timer_pkg.sv */
// Summary of operation
// - two-bit field picks low, timebase or pin
// - clock code 10 stops the timer
// - low pair bit two joins timers
// - low pair carries, lower interrupt suppressed
// - low pair upper clock field ignored
// - mid pair bit five joins timers
// - mid pair carries, lower interrupt suppressed
// - mid pair upper clock field ignored
// - high pair cascade bit joins timers
// - high pair carries, lower interrupt suppressed
// - third timer bit seven selects one-shot
// - fourth timer one-shot ignored when cascaded
// - fifth timer one-shot, upper ignored cascaded
// - bit six sets fourth output polarity
// - cascaded lower read latches upper count
// - cascaded counter write clears both halves
package timer_pkg;
    localparam int                    NUM_TIMERS  = 6;
    localparam int                    NUM_PAIRS   = 3;
    localparam int                    CNT_W       = 8;
    localparam int                    REG_W       = 8;
    localparam int                    ADDR_W      = 16;
    // index order: 0,1,8,9,a,b
    localparam logic [5:0][15:0]      CON0_ADDR   = {16'hf8ee, 16'hf8ea, 16'hf8e6, 16'hf8e2, 16'hf036, 16'hf032};
    localparam logic [5:0][15:0]      CON1_ADDR   = {16'hf8ef, 16'hf8eb, 16'hf8e7, 16'hf8e3, 16'hf037, 16'hf033};
    localparam logic [5:0][15:0]      CNT_ADDR    = {16'hf8ed, 16'hf8e9, 16'hf8e5, 16'hf8e1, 16'hf035, 16'hf031};
    localparam logic [5:0][7:0]       CON0_WMASK  = {8'hc3, 8'ha3, 8'hc3, 8'ha3, 8'h03, 8'h07};
    localparam logic [7:0]            CON0_RESET  = 8'h00;
    localparam logic [7:0]            REG_ZERO    = 8'h00;
    localparam int                    CS_LSB      = 0;
    localparam int                    CASC_BIT_P0 = 2;
    localparam int                    CASC_BIT_HI = 5;
    localparam int                    NEG_BIT     = 6;
    localparam int                    OST_BIT     = 7;
    localparam int                    RUN_BIT     = 0;
    localparam int                    STAT_BIT    = 7;
    typedef enum logic [1:0] {
        CS_LOW = 2'h0,
        CS_HTB = 2'h1,
        CS_OFF = 2'h2,
        CS_EXT = 2'h3
    } clk_sel_t;
endpackage : timer_pkg

/* core/count_clock_select.sv */
module count_clock_select
    import timer_pkg::*;
(
    input  wire logic     ref_clk,
    input  wire logic     rst_b,
    input  wire logic [1:0] sel,
    input  wire logic     lowClk,
    input  wire logic     high_speed_timebase_clock,
    input  wire logic     extClk,
    output logic          tick
);
    typedef struct packed {
        logic lowPrev;
        logic htbPrev;
        logic extPrev;
        logic tick;
    } sel_state_t;

    sel_state_t s_reg;
    sel_state_t s_next;

    always_comb begin
        s_next         = s_reg;
        s_next.lowPrev = lowClk;
        s_next.htbPrev = high_speed_timebase_clock;
        s_next.extPrev = extClk;
        case (clk_sel_t'(sel))
            CS_LOW:  s_next.tick = lowClk && !s_reg.lowPrev;
            CS_HTB:  s_next.tick = high_speed_timebase_clock && !s_reg.htbPrev;
            CS_EXT:  s_next.tick = extClk && !s_reg.extPrev;
            default: s_next.tick = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    offCode_a: assert property (sel == CS_OFF |=> !tick) else $error("tick with prohibited clock code");
    lowEdge_a: assert property ((sel == CS_LOW) && lowClk && !$past(lowClk) |=> tick)
        else $error("low clock edge gave no tick");
endmodule : count_clock_select

/* core/timer_pair.sv */
module timer_pair
    import timer_pkg::*;
#(
    parameter int W = CNT_W
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    input  wire logic         cascade,
    input  wire logic         tickLo,
    input  wire logic         tickHi,
    input  wire logic         oneShotLo,
    input  wire logic         oneShotHi,
    input  wire logic         runData,
    input  wire logic         runWrLo,
    input  wire logic         runWrHi,
    input  wire logic         cntWrLo,
    input  wire logic         cntWrHi,
    input  wire logic         rdLo,
    output logic [W-1:0]      cntLo,
    output logic [W-1:0]      cntHiRd,
    output logic              runLo,
    output logic              runHi,
    output logic              irqLo,
    output logic              irqHi,
    output logic              toggleHi
);
    typedef struct packed {
        logic [W-1:0] lo;
        logic [W-1:0] hi;
        logic [W-1:0] latch;
        logic         runLo;
        logic         runHi;
        logic         irqLo;
        logic         irqHi;
        logic         tog;
    } pair_state_t;

    localparam logic [W-1:0] MAXV = {W{1'b1}};
    localparam logic [W-1:0] ZERO = {W{1'b0}};

    pair_state_t s_reg;
    pair_state_t s_next;
    logic        incLo;
    logic        ovLo;
    logic        incHi;
    logic        ovHi;

    always_comb begin
        s_next = s_reg;
        incLo  = s_reg.runLo && tickLo;
        ovLo   = incLo && (s_reg.lo == MAXV);
        incHi  = cascade ? ovLo : (s_reg.runHi && tickHi);
        ovHi   = incHi && (s_reg.hi == MAXV);
        if (incLo) begin
            s_next.lo = W'(s_reg.lo + 1'b1);
        end
        if (incHi) begin
            s_next.hi = W'(s_reg.hi + 1'b1);
        end
        // a write beats a same-cycle increment
        if (cascade && (cntWrLo || cntWrHi)) begin
            s_next.lo = ZERO;
            s_next.hi = ZERO;
        end else begin
            if (cntWrLo) begin
                s_next.lo = ZERO;
            end
            if (cntWrHi) begin
                s_next.hi = ZERO;
            end
        end
        s_next.irqLo = ovLo && !cascade;
        s_next.irqHi = ovHi;
        if (ovHi) begin
            s_next.tog = ~s_reg.tog;
        end
        if (cascade) begin
            if (ovHi && oneShotLo) begin
                s_next.runLo = 1'b0;
            end
        end else begin
            if (ovLo && oneShotLo) begin
                s_next.runLo = 1'b0;
            end
            if (ovHi && oneShotHi) begin
                s_next.runHi = 1'b0;
            end
        end
        if (runWrLo) begin
            s_next.runLo = runData;
        end
        if (runWrHi) begin
            s_next.runHi = runData;
        end
        if (rdLo && cascade) begin
            s_next.latch = s_reg.hi;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cntLo    = s_reg.lo;
    assign cntHiRd  = cascade ? s_reg.latch : s_reg.hi;
    assign runLo    = s_reg.runLo;
    assign runHi    = s_reg.runHi;
    assign irqLo    = s_reg.irqLo;
    assign irqHi    = s_reg.irqHi;
    assign toggleHi = s_reg.tog;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    lowIrqOff_a: assert property ($past(cascade) |-> !irqLo) else $error("lower irq while cascaded");
    hiCarry_a: assert property (cascade && ovLo && !cntWrLo && !cntWrHi |=> s_reg.hi == W'($past(s_reg.hi) + 1'b1))
        else $error("upper did not carry");
    hiIgnore_a: assert property (cascade && !ovLo && !cntWrLo && !cntWrHi |=> $stable(s_reg.hi))
        else $error("upper moved without carry");
    clearBoth_a: assert property (cascade && (cntWrLo || cntWrHi) |=> s_reg.lo == ZERO && s_reg.hi == ZERO)
        else $error("cascaded write did not clear");
    latchRd_a: assert property (cascade && rdLo |=> !cascade || cntHiRd == $past(s_reg.hi))
        else $error("upper latch wrong");
    upperIrq_a: assert property (cascade && ovHi |=> irqHi) else $error("no cascaded overflow irq");
    oneShot_a: assert property (!cascade && ovLo && oneShotLo && !runWrLo |=> !runLo)
        else $error("one-shot kept running");
    cascWrap_c: cover property (cascade && ovHi);
endmodule : timer_pair

/* testbench/testbench.sv */
module testbench
    import timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              refClk;
    logic              rstB;
    logic [ADDR_W-1:0] sfrAddr;
    logic              sfrWrEn;
    logic              sfrRdEn;
    logic [REG_W-1:0]  sfrWrData;
    logic [REG_W-1:0]  sfrRdData;
    logic              lowClk;
    logic              high_speed_timebase_clock;
    logic [4:0]        extPin;
    logic [5:0]        irq;
    logic              tmOut;
    int                irqCnt [6];
    int                num_errors;
    int                compares;
    int                cycles;
    logic [7:0]        lfsrState;

    paired_timer_mode_control u_dut (
        .ref_clk                (refClk),
        .rst_b                  (rstB),
        .sfrAddr                (sfrAddr),
        .sfrWrEn                (sfrWrEn),
        .sfrRdEn                (sfrRdEn),
        .sfrWrData              (sfrWrData),
        .sfrRdData              (sfrRdData),
        .lowSpeedClock          (lowClk),
        .highSpeedTimebaseClock (high_speed_timebase_clock),
        .firstTimerExtClockPin  (extPin[0]),
        .secondTimerExtClockPin (extPin[1]),
        .thirdTimerExtClockPin  (extPin[2]),
        .fourthTimerExtClockPin (extPin[3]),
        .fifthTimerExtClockPin  (extPin[4]),
        .firstTimerIrq          (irq[0]),
        .secondTimerIrq         (irq[1]),
        .thirdTimerIrq          (irq[2]),
        .fourthTimerIrq         (irq[3]),
        .fifthTimerIrq          (irq[4]),
        .sixthTimerIrq          (irq[5]),
        .fourthTimerOutput      (tmOut)
    );

    initial begin
        refClk = 1'b0;
    end
    always #2.5 refClk = ~refClk;

    // pulses are one cycle wide, so counting edges is exact
    always @(posedge refClk) begin
        for (int i = 0; i < 6; i++) begin
            if (irq[i] === 1'b1) begin
                irqCnt[i]++;
            end
        end
    end

    // whole run needs under 10000 cycles
    always @(posedge refClk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            $display("ERROR timeout expected finish within 40000 cycles seen none");
            give_verdict();
        end
    end

    function automatic logic [7:0] nextRand();
        lfsrState = {lfsrState[6:0], lfsrState[7] ^ lfsrState[5] ^ lfsrState[4] ^ lfsrState[3]};
        return lfsrState;
    endfunction : nextRand

    function automatic logic [7:0] expCon0(int t, logic [7:0] d);
        return d & CON0_WMASK[t];
    endfunction : expCon0

    // code 10 never ticks, other codes count every pulse
    function automatic logic [7:0] expCount(int code, int n);
        return (code == 2) ? 8'h00 : 8'(n);
    endfunction : expCount

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge refClk);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        @(negedge refClk);
        sfrWrEn = 1'b0;
    endtask : wr

    task automatic rdChk(input string what, input logic [15:0] a, input logic [7:0] exp);
        @(negedge refClk);
        sfrAddr = a;
        sfrRdEn = 1'b1;
        @(negedge refClk);
        sfrRdEn = 1'b0;
        chk(what, exp, sfrRdData);
    endtask : rdChk

    // code 2 drives every source at once, so nothing may sneak through
    task automatic pulse(input int code, input int n);
        repeat (n) begin
            @(negedge refClk);
            lowClk = (code == 0 || code == 2);
            high_speed_timebase_clock = (code == 1 || code == 2);
            extPin = (code >= 2) ? 5'h1f : 5'h00;
            @(negedge refClk);
            lowClk = 1'b0;
            high_speed_timebase_clock = 1'b0;
            extPin = 5'h00;
        end
        repeat (4) @(negedge refClk);
    endtask : pulse

    task automatic clrIrq();
        for (int i = 0; i < 6; i++) begin
            irqCnt[i] = 0;
        end
    endtask : clrIrq

    task automatic endTest(input string name);
        $display("test %s done, mismatches so far %0d", name, num_errors);
    endtask : endTest

    initial begin
        logic [7:0] d;
        int         k;
        int         lo;
        int         hi;
        logic       os;
        rstB = 1'b0;
        sfrAddr = '0;
        sfrWrEn = 1'b0;
        sfrRdEn = 1'b0;
        sfrWrData = '0;
        lowClk = 1'b0;
        high_speed_timebase_clock = 1'b0;
        extPin = '0;
        num_errors = 0;
        compares = 0;
        cycles = 0;
        lfsrState = 8'h4b;
        clrIrq();
        repeat (16) @(negedge refClk);
        rstB = 1'b1;

        for (int t = 0; t < 6; t++) begin
            rdChk("con0 reset", CON0_ADDR[t], CON0_RESET);
            d = nextRand();
            wr(CON0_ADDR[t], d);
            rdChk("con0 mask", CON0_ADDR[t], expCon0(t, d));
            wr(CON0_ADDR[t], REG_ZERO);
        end
        wr(16'hf030, 8'hff);
        rdChk("unmapped", 16'hf030, 8'h00);
        endTest("registers");

        for (int t = 0; t < 6; t++) begin
            for (int c = 0; c < 4; c++) begin
                k = int'(nextRand() % 8) + 1;
                wr(CNT_ADDR[t], REG_ZERO);
                wr(CON0_ADDR[t], 8'(c));
                wr(CON1_ADDR[t], 8'h01);
                rdChk("status run", CON1_ADDR[t], 8'h81);
                pulse(c, k);
                wr(CON1_ADDR[t], REG_ZERO);
                rdChk("count", CNT_ADDR[t], expCount(c, k));
            end
            wr(CON0_ADDR[t], REG_ZERO);
        end
        endTest("clock select");

        // polarity first, while the timer 9 toggle is still at its reset level
        wr(CON0_ADDR[3], 8'h40);
        repeat (3) @(negedge refClk);
        chk("neg idle out", 8'h01, {7'h0, tmOut});
        wr(CNT_ADDR[3], REG_ZERO);
        wr(CON1_ADDR[3], 8'h01);
        clrIrq();
        pulse(0, 256);
        chk("neg toggled out", 8'h00, {7'h0, tmOut});
        chk("timer9 irq", 8'h01, 8'(irqCnt[3]));
        wr(CON1_ADDR[3], REG_ZERO);
        wr(CON0_ADDR[3], REG_ZERO);
        repeat (2) @(negedge refClk);
        chk("pos toggled out", 8'h01, {7'h0, tmOut});
        // timers 0 and 1 have no one-shot bit, so they run on past the wrap
        for (int t = 0; t < 6; t++) begin
            os = CON0_WMASK[t][OST_BIT];
            wr(CNT_ADDR[t], REG_ZERO);
            wr(CON0_ADDR[t], 8'h80);
            wr(CON1_ADDR[t], 8'h01);
            clrIrq();
            pulse(0, 259);
            chk("wrap irq", 8'h01, 8'(irqCnt[t]));
            rdChk("one-shot count", CNT_ADDR[t], os ? 8'h00 : 8'h03);
            rdChk("one-shot run", CON1_ADDR[t], os ? 8'h00 : 8'h81);
            wr(CON1_ADDR[t], REG_ZERO);
            wr(CON0_ADDR[t], REG_ZERO);
        end
        endTest("one-shot and polarity");

        for (int p = 0; p < 3; p++) begin
            lo = 2 * p;
            hi = 2 * p + 1;
            // upper gets prohibited code and, outside the low pair, one-shot; both must be ignored
            wr(CON0_ADDR[hi], 8'h82);
            wr(CON0_ADDR[lo], (p == 0) ? 8'h04 : 8'h20);
            wr(CNT_ADDR[lo], REG_ZERO);
            wr(CON1_ADDR[lo], 8'h01);
            rdChk("upper stat", CON1_ADDR[hi], 8'h00);
            clrIrq();
            k = int'(nextRand() % 8) + 1;
            pulse(0, 256 + k);
            rdChk("cascade low", CNT_ADDR[lo], 8'(k));
            rdChk("cascade high", CNT_ADDR[hi], 8'h01);
            chk("low irq muted", 8'h00, 8'(irqCnt[lo]));
            chk("high irq quiet", 8'h00, 8'(irqCnt[hi]));
            pulse(0, 256);
            rdChk("latched high", CNT_ADDR[hi], 8'h01);
            rdChk("low again", CNT_ADDR[lo], 8'(k));
            rdChk("high fresh", CNT_ADDR[hi], 8'h02);
            wr(CNT_ADDR[hi], 8'h5a);
            rdChk("clear low", CNT_ADDR[lo], 8'h00);
            rdChk("clear high", CNT_ADDR[hi], 8'h00);
            wr(CON1_ADDR[lo], REG_ZERO);
            wr(CON0_ADDR[lo], REG_ZERO);
            wr(CON0_ADDR[hi], REG_ZERO);
        end
        endTest("cascade");
        give_verdict();
    end
endmodule : testbench
